// file: pkg/sat_cfg.svh
// register map, field positions, reset values and timing counts of the serial transceiver
//------------------------------------------------------------
// Summary of operation
// - asynchronous or clocked synchronous serial mode, chosen by a control bit
// - bit period at least 16 clocks asynchronous, 8 clocks synchronous
// - transmitter and receiver run at the same time, independently
// - character length 7, 8 or 9 bits, same at both ends
// - even, odd or no parity, generated on transmit, checked on receive
// - one or two stop bits appended per character
// - data bits sent and assembled lsb first or msb first
// - receiver flags parity, overrun and framing errors
// - automatic flow: drive rts to throttle, hold transmit while cts deasserted
// - infrared encoder shapes bits into pulses, decoder recovers them
// - rs485 mode drives line driver enable while transmitting
// - transmit and receive fifos each eight characters deep
// - four interrupt kinds: line status, tx empty, rx threshold, rx time-out
// - readable status and flag register with parity, overrun, framing, break
//------------------------------------------------------------
`ifndef SAT_CFG_SVH
`define SAT_CFG_SVH
`define SAT_ADDR_DATA 8'h00
`define SAT_ADDR_CTRL 8'h04
`define SAT_ADDR_BAUD 8'h08
`define SAT_ADDR_FCTL 8'h0c
`define SAT_ADDR_FLAGS 8'h10
`define SAT_ADDR_MASK 8'h14
`define SAT_CTRL_RST 12'h00b
`define SAT_BAUD_RST 16'h01b2
`define SAT_THR_RST 4'h4
`define SAT_TO_RST 4'h4
`define SAT_FCTL_THR_LSB 0
`define SAT_FCTL_TO_LSB 8
`define SAT_F_PE 0
`define SAT_F_FE 1
`define SAT_F_OE 2
`define SAT_F_BI 3
`define SAT_F_TXE 4
`define SAT_F_RXT 5
`define SAT_F_TO 6
`define SAT_NFLAGS 7
`define SAT_F_TXFULL 8
`define SAT_F_RXEMPTY 9
`define SAT_TXCNT_LSB 12
`define SAT_RXCNT_LSB 16
`define SAT_ASYNC_MIN_DIV 16'h0010
`define SAT_SYNC_MIN_DIV 16'h0008
`define SAT_IR_NUM 18'h00003
`define SAT_FIFO_DEPTH 8
`define SAT_RESP_OK 2'h0
`define SAT_RESP_ERR 2'h2
`endif

// file: pkg/sat_pkg.sv
// types shared by the serial transceiver modules
package sat_pkg;
   typedef enum logic [1:0] {SAT_TX_IDLE, SAT_TX_LOAD, SAT_TX_SHIFT} sat_txst_t;
   typedef enum logic [1:0] {SAT_RX_IDLE, SAT_RX_START, SAT_RX_DATA} sat_rxst_t;
   typedef struct packed {
      logic rs485;
      logic irda;
      logic autoFlow;
      logic msbFirst;
      logic stop2;
      logic parOdd;
      logic parEn;
      logic [1:0] wordLen;
      logic syncMode;
      logic txEn;
      logic rxEn;
   } sat_ctrl_t;
   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } sat_axi_in_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sat_axi_out_t;
   typedef struct packed {
      logic rx;
      logic ctsN;
   } sat_line_in_t;
   typedef struct packed {
      logic tx;
      logic rtsN;
      logic sclk;
      logic drvEn;
   } sat_line_out_t;
endpackage

// file: src/sat_fifo_mem.sv
// small register-file memory with registered read data, one per fifo
`timescale 1ns/1ps
module sat_fifo_mem #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic clock,
   input wire logic wrEn,
   input wire logic [$clog2(DEPTH)-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   input wire logic [$clog2(DEPTH)-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData
);
   import sat_pkg::*;
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0] rdData;
   } sat_mem_state_t;
   sat_mem_state_t s;
   sat_mem_state_t n;
   // write-first: a word pushed into an empty fifo is readable at once, never stale
   always_comb begin
      n = s;
      if (wrEn) begin
         n.mem[wrAddr] = wrData;
      end
      n.rdData = n.mem[rdAddr];
   end
   always_ff @(posedge clock) begin
      s <= n;
   end
   assign rdData = s.rdData;
endmodule

// file: src/sat_serial_transceiver.sv
// serial transceiver: axi4-lite registers, fifos, transmitter, receiver, flow control
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sat_cfg.svh"
module sat_serial_transceiver #(
   parameter int DEPTH = `SAT_FIFO_DEPTH,
   parameter int WIDTH = 9
) (
   input wire logic clock,
   input wire logic srst,
   input sat_pkg::sat_axi_in_t axiIn,
   output sat_pkg::sat_axi_out_t axiOut,
   input sat_pkg::sat_line_in_t lineIn,
   output sat_pkg::sat_line_out_t lineOut,
   output logic irq
);
   import sat_pkg::*;
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW:0] NEAR_FULL = (AW+1)'(DEPTH - 1);

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic awHave;
      logic wHave;
      logic [7:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic rdPend;
      logic [7:0] arAddr;
      sat_ctrl_t ctrl;
      logic [15:0] baud;
      logic [3:0] rxThr;
      logic [3:0] toChars;
      logic [`SAT_NFLAGS-1:0] flags;
      logic [`SAT_NFLAGS-1:0] mask;
      logic irq;
      logic [AW-1:0] txWp;
      logic [AW-1:0] txRp;
      logic [AW-1:0] rxWp;
      logic [AW-1:0] rxRp;
      logic [AW:0] txCnt;
      logic [AW:0] rxCnt;
      sat_txst_t txSt;
      logic [15:0] txDiv;
      logic [3:0] txBit;
      logic [12:0] txShift;
      logic txOut;
      logic sclk;
      logic drvEn;
      logic rtsN;
      logic rxS1;
      logic rxS2;
      logic ctsS1;
      logic ctsS2;
      logic [15:0] irStretch;
      sat_rxst_t rxSt;
      logic [15:0] rxDiv;
      logic [3:0] rxBit;
      logic [11:0] rxShift;
      logic [15:0] toDiv;
      logic [7:0] toBits;
   } sat_state_t;

   sat_state_t s;
   sat_state_t n;
   logic [WIDTH-1:0] txHead;
   logic [WIDTH-1:0] rxHead;
   logic txPush;
   logic txPop;
   logic rxPush;
   logic rxPop;
   logic rxDone;
   logic rxLine;
   logic [WIDTH-1:0] rxWord;
   logic [11:0] got;
   logic [11:0] gotMask;
   logic [`SAT_NFLAGS-1:0] ev;
   logic [`SAT_NFLAGS-1:0] clr;
   logic [31:0] wv;
   logic [15:0] per;
   logic [15:0] irLen;
   logic [17:0] irProd;
   logic [3:0] nb;
   logic [3:0] fb;
   logic [3:0] lastRx;
   logic [7:0] toLimit;
   logic active;

   //------------------------------------------------------------
   // framing helpers
   //------------------------------------------------------------
   function automatic logic [15:0] bitPeriod(input sat_ctrl_t c, input logic [15:0] b);
      logic [15:0] m;
      m = c.syncMode ? `SAT_SYNC_MIN_DIV : `SAT_ASYNC_MIN_DIV;
      return (b < m) ? m : b;
   endfunction

   function automatic logic [3:0] dataBits(input sat_ctrl_t c);
      return (c.wordLen[1]) ? 4'h9 : 4'h7 + {3'h0, c.wordLen[0]};
   endfunction

   function automatic logic [3:0] frameBits(input sat_ctrl_t c);
      return 4'h1 + dataBits(c) + {3'h0, c.parEn} + (c.stop2 ? 4'h2 : 4'h1);
   endfunction

   // line order, bit 0 first; unused tail stays high so stop bits fall out naturally
   function automatic logic [12:0] buildFrame(input sat_ctrl_t c, input logic [8:0] d);
      logic [12:0] f;
      logic [3:0] k;
      logic p;
      f = '1;
      k = dataBits(c);
      p = c.parOdd;
      f[0] = 1'b0;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(k)) begin
            f[i+1] = c.msbFirst ? d[int'(k)-1-i] : d[i];
            p = p ^ d[i];
         end
      end
      if (c.parEn) begin
         f[k+4'h1] = p;
      end
      return f;
   endfunction

   function automatic logic [8:0] takeData(input sat_ctrl_t c, input logic [11:0] r);
      logic [8:0] d;
      logic [3:0] k;
      d = '0;
      k = dataBits(c);
      for (int i = 0; i < 9; i++) begin
         if (i < int'(k)) begin
            d[i] = c.msbFirst ? r[int'(k)-1-i] : r[i];
         end
      end
      return d;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a == `SAT_ADDR_DATA || a == `SAT_ADDR_CTRL || a == `SAT_ADDR_BAUD ||
         a == `SAT_ADDR_FCTL || a == `SAT_ADDR_FLAGS || a == `SAT_ADDR_MASK;
   endfunction

   function automatic logic [31:0] regRead(input sat_state_t st, input logic [7:0] a, input logic [8:0] head);
      logic [31:0] r;
      r = '0;
      case (a)
         `SAT_ADDR_DATA: r[8:0] = head;
         `SAT_ADDR_CTRL: r[11:0] = st.ctrl;
         `SAT_ADDR_BAUD: r[15:0] = st.baud;
         `SAT_ADDR_FCTL: begin
            r[`SAT_FCTL_THR_LSB +: 4] = st.rxThr;
            r[`SAT_FCTL_TO_LSB +: 4] = st.toChars;
         end
         `SAT_ADDR_FLAGS: begin
            r[`SAT_NFLAGS-1:0] = st.flags;
            r[`SAT_F_TXFULL] = st.txCnt == FULL;
            r[`SAT_F_RXEMPTY] = st.rxCnt == '0;
            r[`SAT_TXCNT_LSB +: 4] = 4'(st.txCnt);
            r[`SAT_RXCNT_LSB +: 4] = 4'(st.rxCnt);
         end
         `SAT_ADDR_MASK: r[`SAT_NFLAGS-1:0] = st.mask;
         default: r = '0;
      endcase
      return r;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   //------------------------------------------------------------
   // next state
   //------------------------------------------------------------
   always_comb begin
      n = s;
      txPush = 1'b0;
      txPop = 1'b0;
      rxPush = 1'b0;
      rxPop = 1'b0;
      rxDone = 1'b0;
      ev = '0;
      clr = '0;
      wv = '0;
      per = bitPeriod(s.ctrl, s.baud);
      nb = dataBits(s.ctrl);
      fb = frameBits(s.ctrl);
      lastRx = nb + {3'h0, s.ctrl.parEn};
      irProd = {2'h0, per} * `SAT_IR_NUM;
      irLen = {2'h0, irProd[17:4]};
      toLimit = {4'h0, s.toChars} * {4'h0, fb};
      // line pins come from another domain
      n.rxS1 = lineIn.rx;
      n.rxS2 = s.rxS1;
      n.ctsS1 = lineIn.ctsN;
      n.ctsS2 = s.ctsS1;
      // infrared decoder: a high pulse marks a zero bit, stretched over one bit period
      if (s.rxS2) begin
         n.irStretch = per;
      end else if (s.irStretch != '0) begin
         n.irStretch = s.irStretch - 16'h0001;
      end
      rxLine = s.ctrl.irda ? (s.irStretch == '0) : s.rxS2;

      // register writes
      if (axiIn.awvalid && s.awready) begin
         n.awHave = 1'b1;
         n.awAddr = axiIn.awaddr;
      end
      if (axiIn.wvalid && s.wready) begin
         n.wHave = 1'b1;
         n.wData = axiIn.wdata;
         n.wStrb = axiIn.wstrb;
      end
      if (s.bvalid && axiIn.bready) begin
         n.bvalid = 1'b0;
      end
      if (s.awHave && s.wHave && !s.bvalid) begin
         n.awHave = 1'b0;
         n.wHave = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = mapped(s.awAddr) ? `SAT_RESP_OK : `SAT_RESP_ERR;
         wv = merge(regRead(s, s.awAddr, rxHead), s.wData, s.wStrb);
         case (s.awAddr)
            `SAT_ADDR_DATA: txPush = s.wStrb[0] && s.txCnt != FULL;
            `SAT_ADDR_CTRL: n.ctrl = sat_ctrl_t'(wv[11:0]);
            `SAT_ADDR_BAUD: n.baud = wv[15:0];
            `SAT_ADDR_FCTL: begin
               n.rxThr = wv[`SAT_FCTL_THR_LSB +: 4];
               n.toChars = wv[`SAT_FCTL_TO_LSB +: 4];
            end
            `SAT_ADDR_FLAGS: clr = s.wStrb[0] ? s.wData[`SAT_NFLAGS-1:0] : '0;
            `SAT_ADDR_MASK: n.mask = wv[`SAT_NFLAGS-1:0];
            default: n.bresp = `SAT_RESP_ERR;
         endcase
      end
      n.awready = !n.awHave && !n.bvalid;
      n.wready = !n.wHave && !n.bvalid;

      // register reads, one cycle behind the address so the fifo head has settled
      if (axiIn.arvalid && s.arready) begin
         n.rdPend = 1'b1;
         n.arAddr = axiIn.araddr;
      end
      if (s.rvalid && axiIn.rready) begin
         n.rvalid = 1'b0;
      end
      if (s.rdPend) begin
         n.rdPend = 1'b0;
         n.rvalid = 1'b1;
         n.rdata = regRead(s, s.arAddr, rxHead);
         n.rresp = mapped(s.arAddr) ? `SAT_RESP_OK : `SAT_RESP_ERR;
         rxPop = s.arAddr == `SAT_ADDR_DATA && s.rxCnt != '0;
      end
      n.arready = !n.rdPend && !n.rvalid;

      //------------------------------------------------------------
      // transmitter
      //------------------------------------------------------------
      case (s.txSt)
         SAT_TX_IDLE: begin
            if (s.ctrl.txEn && s.txCnt != '0 && !(s.ctrl.autoFlow && s.ctsS2)) begin
               n.txSt = SAT_TX_LOAD;
            end
         end
         SAT_TX_LOAD: begin
            n.txShift = buildFrame(s.ctrl, txHead);
            txPop = 1'b1;
            n.txDiv = '0;
            n.txBit = '0;
            n.txSt = SAT_TX_SHIFT;
         end
         SAT_TX_SHIFT: begin
            if (s.txDiv == per - 16'h0001) begin
               n.txDiv = '0;
               n.txShift = {1'b1, s.txShift[12:1]};
               n.txBit = s.txBit + 4'h1;
               if (s.txBit == fb - 4'h1) begin
                  n.txSt = SAT_TX_IDLE;
               end
            end else begin
               n.txDiv = s.txDiv + 16'h0001;
            end
         end
         default: n.txSt = SAT_TX_IDLE;
      endcase
      active = n.txSt == SAT_TX_SHIFT;
      if (!active) begin
         n.txOut = !s.ctrl.irda;
      end else if (s.ctrl.irda) begin
         n.txOut = !n.txShift[0] && n.txDiv < irLen;
      end else begin
         n.txOut = n.txShift[0];
      end
      // synchronous mode: clock rises mid-bit for data bits only
      n.sclk = s.ctrl.syncMode && active && n.txBit != '0 && n.txBit <= nb && n.txDiv >= (per >> 1);
      n.drvEn = s.ctrl.rs485 && n.txSt != SAT_TX_IDLE;

      //------------------------------------------------------------
      // receiver
      //------------------------------------------------------------
      case (s.rxSt)
         SAT_RX_IDLE: begin
            if (s.ctrl.rxEn && !rxLine) begin
               n.rxSt = SAT_RX_START;
               n.rxDiv = '0;
            end
         end
         SAT_RX_START: begin
            if (s.rxDiv == (per >> 1) - 16'h0001) begin
               n.rxDiv = '0;
               n.rxBit = '0;
               n.rxShift = '0;
               n.rxSt = rxLine ? SAT_RX_IDLE : SAT_RX_DATA;
            end else begin
               n.rxDiv = s.rxDiv + 16'h0001;
            end
         end
         SAT_RX_DATA: begin
            if (s.rxDiv == per - 16'h0001) begin
               n.rxDiv = '0;
               n.rxShift[s.rxBit] = rxLine;
               n.rxBit = s.rxBit + 4'h1;
               if (s.rxBit == lastRx) begin
                  n.rxSt = SAT_RX_IDLE;
                  rxDone = 1'b1;
               end
            end else begin
               n.rxDiv = s.rxDiv + 16'h0001;
            end
         end
         default: n.rxSt = SAT_RX_IDLE;
      endcase
      got = n.rxShift;
      gotMask = ~(12'hfff << (lastRx + 4'h1));
      rxWord = takeData(s.ctrl, got);
      if (rxDone) begin
         ev[`SAT_F_PE] = s.ctrl.parEn && ((^rxWord) ^ s.ctrl.parOdd ^ got[nb]);
         ev[`SAT_F_FE] = !got[lastRx];
         ev[`SAT_F_BI] = (got & gotMask) == '0;
         if (s.rxCnt != FULL || rxPop) begin
            rxPush = 1'b1;
         end else begin
            ev[`SAT_F_OE] = 1'b1;
         end
      end

      //------------------------------------------------------------
      // fifo bookkeeping
      //------------------------------------------------------------
      if (txPush) begin
         n.txWp = s.txWp + 1'b1;
      end
      if (txPop) begin
         n.txRp = s.txRp + 1'b1;
      end
      n.txCnt = s.txCnt + (AW+1)'(txPush) - (AW+1)'(txPop);
      if (rxPush) begin
         n.rxWp = s.rxWp + 1'b1;
      end
      if (rxPop) begin
         n.rxRp = s.rxRp + 1'b1;
      end
      n.rxCnt = s.rxCnt + (AW+1)'(rxPush) - (AW+1)'(rxPop);
      ev[`SAT_F_TXE] = txPop && !txPush && s.txCnt == (AW+1)'(1);
      ev[`SAT_F_RXT] = rxPush && 4'(n.rxCnt) == s.rxThr;

      // quiet-line counter in bit periods; stops once it has fired
      if (rxPush || rxPop || s.rxSt != SAT_RX_IDLE || s.rxCnt == '0) begin
         n.toDiv = '0;
         n.toBits = '0;
      end else if (s.toBits != toLimit) begin
         if (s.toDiv == per - 16'h0001) begin
            n.toDiv = '0;
            n.toBits = s.toBits + 8'h01;
            ev[`SAT_F_TO] = n.toBits == toLimit;
         end else begin
            n.toDiv = s.toDiv + 16'h0001;
         end
      end

      // throttle the far sender one slot before the receive fifo fills
      n.rtsN = s.ctrl.autoFlow && n.rxCnt >= NEAR_FULL;
      // a hardware event in the clearing cycle survives
      n.flags = (s.flags & ~clr) | ev;
      n.irq = |(n.flags & n.mask);

      if (srst) begin
         n = '0;
         n.ctrl = sat_ctrl_t'(`SAT_CTRL_RST);
         n.baud = `SAT_BAUD_RST;
         n.rxThr = `SAT_THR_RST;
         n.toChars = `SAT_TO_RST;
         n.txSt = SAT_TX_IDLE;
         n.rxSt = SAT_RX_IDLE;
         n.txOut = 1'b1;
         n.rxS1 = 1'b1;
         n.rxS2 = 1'b1;
         n.ctsS1 = 1'b1;
         n.ctsS2 = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      s <= n;
   end

   //------------------------------------------------------------
   // fifo storage
   //------------------------------------------------------------
   sat_fifo_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) txMem (
      .clock(clock),
      .wrEn(txPush),
      .wrAddr(s.txWp),
      .wrData(s.wData[WIDTH-1:0]),
      .rdAddr(s.txRp),
      .rdData(txHead)
   );

   sat_fifo_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) rxMem (
      .clock(clock),
      .wrEn(rxPush),
      .wrAddr(s.rxWp),
      .wrData(rxWord),
      .rdAddr(s.rxRp),
      .rdData(rxHead)
   );

   assign axiOut.awready = s.awready;
   assign axiOut.wready = s.wready;
   assign axiOut.bvalid = s.bvalid;
   assign axiOut.bresp = s.bresp;
   assign axiOut.arready = s.arready;
   assign axiOut.rvalid = s.rvalid;
   assign axiOut.rdata = s.rdata;
   assign axiOut.rresp = s.rresp;
   assign lineOut.tx = s.txOut;
   assign lineOut.rtsN = s.rtsN;
   assign lineOut.sclk = s.sclk;
   assign lineOut.drvEn = s.drvEn;
   assign irq = s.irq;
endmodule

// file: testbench/sat_serial_transceiver_properties.sv
// port assertions of the serial transceiver
`timescale 1ns/1ps
`include "sat_cfg.svh"
module sat_serial_transceiver_properties (
   input wire logic clock,
   input wire logic srst,
   input sat_pkg::sat_axi_in_t axiIn,
   input sat_pkg::sat_axi_out_t axiOut,
   input sat_pkg::sat_line_in_t lineIn,
   input sat_pkg::sat_line_out_t lineOut,
   input wire logic irq
);
   import sat_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   a_reset_lines: assert property ($fell(srst) |-> lineOut.tx && !lineOut.drvEn && !irq)
      else $error("line outputs not idle after reset");
   a_reset_bus: assert property ($fell(srst) |-> (!axiOut.bvalid && !axiOut.rvalid) ##1 axiOut.arready)
      else $error("bus not ready after reset");
   a_write_answer: assert property (axiIn.awvalid && axiOut.awready && axiIn.wvalid && axiOut.wready
      |-> ##2 axiOut.bvalid)
      else $error("write response late");
   a_read_answer: assert property (axiIn.arvalid && axiOut.arready |-> ##2 axiOut.rvalid)
      else $error("read data late");
   a_bresp_hold: assert property (axiOut.bvalid && !axiIn.bready |=> axiOut.bvalid && $stable(axiOut.bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (axiOut.rvalid && !axiIn.rready |=> axiOut.rvalid && $stable(axiOut.rdata))
      else $error("read data dropped");
   a_write_block: assert property (axiOut.bvalid |-> !axiOut.awready && !axiOut.wready)
      else $error("write taken while response pending");
   a_read_block: assert property (axiOut.rvalid |-> !axiOut.arready)
      else $error("read taken while data pending");
   // shortest legal low stretch is 7 clocks, the infrared gap after a 1-clock pulse in a sync bit of 8 clocks
   a_bit_width: assert property ($fell(lineOut.tx) |-> !lineOut.tx [*7])
      else $error("serial bit too short");
   a_sclk_mid_bit: assert property ($rose(lineOut.sclk) |-> $stable(lineOut.tx) [*4])
      else $error("sync clock rose near a data change");
endmodule
bind sat_serial_transceiver sat_serial_transceiver_properties u_props (.clock(clock), .srst(srst), .axiIn(axiIn),
   .axiOut(axiOut), .lineIn(lineIn), .lineOut(lineOut), .irq(irq));

// file: testbench/sat_remote_serial.sv
// remote serial device model at the line side
`timescale 1ns/1ps
module sat_remote_serial #(
   parameter int BIT = 16
) (
   input wire logic clock,
   input sat_pkg::sat_line_out_t lineOut,
   output sat_pkg::sat_line_in_t lineIn
);
   import sat_pkg::*;
   initial lineIn = '{rx: 1'b1, ctsN: 1'b0};
   // samples mid-bit; bits come back in line order, start bit first
   task automatic getFrame(input int n, output logic [12:0] f, output logic en, output logic ok);
      int i;
      f = '1;
      en = 1'b1;
      ok = 1'b0;
      for (i = 0; i < 4000 && !ok; i++) begin
         @(negedge clock);
         ok = !lineOut.tx;
      end
      repeat (BIT / 2) @(negedge clock);
      for (i = 0; i < n; i++) begin
         f[i] = lineOut.tx;
         en &= lineOut.drvEn;
         if (i < n - 1) begin
            repeat (BIT) @(negedge clock);
         end
      end
   endtask
   task automatic sendFrame(input logic [12:0] f, input int n);
      int i;
      for (i = 0; i < n; i++) begin
         @(posedge clock);
         lineIn.rx <= f[i];
         repeat (BIT - 1) @(posedge clock);
      end
      @(posedge clock);
      lineIn.rx <= 1'b1;
   endtask
endmodule

// file: testbench/sat_serial_transceiver_tb.sv
// self-checking bench of the serial transceiver
`timescale 1ns/1ps
`include "sat_cfg.svh"
module sat_serial_transceiver_tb;
   import sat_pkg::*;
   localparam logic [7:0] DAT = `SAT_ADDR_DATA;
   localparam logic [7:0] CTL = `SAT_ADDR_CTRL;
   localparam logic [7:0] FL = `SAT_ADDR_FLAGS;
   localparam logic [7:0] MSK = `SAT_ADDR_MASK;
   logic clock = 1'b0;
   logic srst = 1'b1;
   sat_axi_in_t axiIn = '0;
   sat_axi_out_t axiOut;
   sat_line_in_t lineIn;
   sat_line_out_t lineOut;
   logic irq;
   logic [31:0] rdv;
   logic [1:0] rsp;
   int failures = 0;
   int checked = 0;
   int seed = 32'h30edef2b;
   always #10 clock = ~clock;
   sat_serial_transceiver DUT (.clock(clock), .srst(srst), .axiIn(axiIn), .axiOut(axiOut), .lineIn(lineIn),
      .lineOut(lineOut), .irq(irq));
   sat_remote_serial peer (.clock(clock), .lineOut(lineOut), .lineIn(lineIn));
   task automatic end_of_test;
      if (failures == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hang;
      failures++;
      $display("mismatch at %0t: no answer", $time);
      end_of_test();
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      int i;
      @(posedge clock);
      axiIn.awaddr <= a;
      axiIn.wdata <= d;
      axiIn.wstrb <= 4'hf;
      axiIn.awvalid <= 1'b1;
      axiIn.wvalid <= 1'b1;
      axiIn.bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(negedge clock);
         ta = axiIn.awvalid && axiOut.awready;
         tw = axiIn.wvalid && axiOut.wready;
         tb = axiOut.bvalid;
         rsp = axiOut.bresp;
         @(posedge clock);
         if (ta) axiIn.awvalid <= 1'b0;
         if (tw) axiIn.wvalid <= 1'b0;
         if (tb) begin
            axiIn.bready <= 1'b0;
            return;
         end
      end
      hang();
   endtask
   task automatic axr(input logic [7:0] a);
      logic ta, tr;
      int i;
      @(posedge clock);
      axiIn.araddr <= a;
      axiIn.arvalid <= 1'b1;
      axiIn.rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(negedge clock);
         ta = axiIn.arvalid && axiOut.arready;
         tr = axiOut.rvalid;
         rdv = axiOut.rdata;
         rsp = axiOut.rresp;
         @(posedge clock);
         if (ta) axiIn.arvalid <= 1'b0;
         if (tr) begin
            axiIn.rready <= 1'b0;
            return;
         end
      end
      hang();
   endtask
   task automatic lineIs(input int v, input logic e);
      repeat (3) @(negedge clock);
      chk({31'h0, v == 0 ? irq : v == 1 ? lineOut.rtsN : lineOut.tx}, {31'h0, e});
   endtask
   // expected line bits of one character, start bit at index 0; returns bit count
   function automatic int mkFrame(input logic [11:0] c, input logic [8:0] w, output logic [12:0] f);
      int n, d, i;
      logic p, b;
      d = (c[4:3] == 2'h0) ? 7 : (c[4:3] == 2'h1) ? 8 : 9;
      f = '1;
      f[0] = 1'b0;
      n = 1;
      p = c[6];
      for (i = 0; i < d; i++) begin
         b = c[8] ? w[d-1-i] : w[i];
         f[n] = b;
         p ^= b;
         n++;
      end
      if (c[5]) begin
         f[n] = p;
         n++;
      end
      return n + (c[7] ? 2 : 1);
   endfunction
   initial begin
      logic [11:0] c;
      logic [12:0] f, g;
      logic [8:0] w, q[$];
      logic en, ok;
      int n, k;
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      axr(CTL);
      chk(rdv, 32'h0000000b);
      axr(`SAT_ADDR_BAUD);
      chk(rdv, 32'h000001b2);
      axr(`SAT_ADDR_FCTL);
      chk(rdv, 32'h00000404);
      axr(FL);
      chk(rdv & 32'h0000027f, 32'h00000200);
      axr(8'h18);
      chk(32'(rsp), 32'(`SAT_RESP_ERR));
      axw(`SAT_ADDR_BAUD, 32'h10);
      chk(32'(rsp), 32'(`SAT_RESP_OK));
      // full duplex: a random character goes out while the same one comes in
      for (k = 0; k < 12; k++) begin
         c = 12'($random(seed)) & 12'h9fc | 12'h003;
         w = 9'($random(seed));
         n = mkFrame(c, w, f);
         axw(CTL, {20'h0, c});
         axw(DAT, {23'h0, w});
         fork
            peer.getFrame(n, g, en, ok);
            peer.sendFrame(f, n);
         join
         if (ok !== 1'b1) hang();
         chk({19'h0, g}, {19'h0, f});
         if (c[11]) chk({31'h0, en}, 32'h1);
         axr(DAT);
         chk(rdv, {23'h0, w & (9'h1ff >> (c[4:3] == 2'h0 ? 2 : c[4:3] == 2'h1 ? 1 : 0))});
         axr(FL);
         chk(rdv & 32'hf, 32'h0);
      end
      // parity, framing and break, each with its own flag pattern
      axw(CTL, 32'h02b);
      axw(FL, 32'h7f);
      axw(MSK, 32'h1);
      for (k = 0; k < 3; k++) begin
         n = mkFrame(12'h02b, 9'h0a5, f);
         if (k == 0) f[9] = ~f[9];
         if (k == 1) f[10] = 1'b0;
         if (k == 2) f = '0;
         peer.sendFrame(f, n);
         axr(DAT);
         axr(FL);
         chk(rdv & 32'hf, k == 0 ? 32'h1 : k == 1 ? 32'h2 : 32'ha);
         lineIs(0, k == 0);
         axw(FL, 32'h7f);
         lineIs(0, 1'b0);
      end
      axw(FL, 32'h0);
      // masking hides a set flag
      peer.sendFrame('0, 11);
      axw(MSK, 32'h0);
      lineIs(0, 1'b0);
      axw(MSK, 32'h8);
      lineIs(0, 1'b1);
      axr(DAT);
      axw(FL, 32'h7f);
      // nine characters into an eight deep receiver
      axw(CTL, 32'h20b);
      for (k = 0; k < 9; k++) begin
         n = mkFrame(12'h20b, 9'($random(seed)), f);
         peer.sendFrame(f, n);
      end
      axr(FL);
      chk(rdv & 32'hf0024, 32'h80024);
      lineIs(1, 1'b1);
      repeat (800) @(negedge clock);
      axr(FL);
      chk(rdv & 32'h40, 32'h40);
      for (k = 0; k < 8; k++) axr(DAT);
      axr(FL);
      chk(rdv & 32'hf0200, 32'h00200);
      lineIs(1, 1'b0);
      // transmitter held off by the remote side until its fifo is full
      peer.lineIn.ctsN <= 1'b1;
      for (k = 0; k < 9; k++) begin
         q.push_back(9'($random(seed)) & 9'h0ff);
         axw(DAT, {23'h0, q[k]});
      end
      lineIs(2, 1'b1);
      axr(FL);
      chk(rdv & 32'hf100, 32'h8100);
      axw(FL, 32'h10);
      peer.lineIn.ctsN <= 1'b0;
      for (k = 0; k < 8; k++) begin
         n = mkFrame(12'h20b, q[k], f);
         peer.getFrame(n, g, en, ok);
         if (ok !== 1'b1) hang();
         chk({19'h0, g}, {19'h0, f});
      end
      repeat (20) @(negedge clock);
      axr(FL);
      chk(rdv & 32'hf010, 32'h0010);
      end_of_test();
   end
endmodule
